// ### logic/sccr_pkg.sv
// Shared constants and carrier types for the switch capability register group
package sccr_pkg;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] OFF_MSG_PAYLOAD = 8'h58;
  localparam logic [7:0] OFF_PD_ACCESS = 8'h5C;
  localparam logic [7:0] OFF_VENDOR_CAP = 8'h64;
  localparam logic [7:0] OFF_TEST_A = 8'h68;
  localparam logic [7:0] OFF_TEST_B = 8'h6C;
  localparam logic [7:0] OFF_TIMER_OVR = 8'h70;

  // ****************************************
  // Fixed header values and reset values
  // ****************************************
  localparam logic [7:0] PD_CAP_ID = 8'h03;
  localparam logic [7:0] PD_NEXT_PTR = 8'h64;
  localparam logic [7:0] VENDOR_CAP_ID = 8'h09;
  localparam logic [7:0] VENDOR_NEXT_PTR = 8'hB0;
  localparam logic [15:0] VENDOR_CAP_LEN = 16'h0034;
  localparam logic [31:0] TEST_A_RST = 32'h0400_1060;
  localparam logic [31:0] TEST_B_RST = 32'h0400_0800;
  localparam logic [15:0] MSG_PAYLOAD_RST = 16'h0000;
  localparam logic [5:0] PD_INDEX_RST = 6'h00;
  localparam logic PD_FLAG_RST = 1'b0;
  localparam logic [11:0] REPLAY_USER_RST = 12'h000;
  localparam logic [13:0] ACK_USER_RST = 14'h0000;
  localparam logic VGA_DECODE_VAL = 1'b1;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int PD_INDEX_LSB = 18;
  localparam int PD_INDEX_MSB = 23;
  localparam int PD_FLAG_BIT = 31;
  localparam int REPLAY_USER_MSB = 11;
  localparam int REPLAY_EN_BIT = 12;
  localparam int PM_DIS_BIT = 13;
  localparam int MSI_DIS_BIT = 14;
  localparam int ACK_USER_LSB = 16;
  localparam int ACK_USER_MSB = 29;
  localparam int ACK_EN_BIT = 30;
  localparam int VGA_BIT = 31;

  // ****************************************
  // Carrier types
  // ****************************************
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } sccr_cfg_req_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [5:0] index;
  } sccr_ee_req_t;

  typedef struct packed {
    logic valid;
    logic [29:0] addr;
    logic [15:0] data;
  } sccr_msi_wr_t;

  typedef enum logic {PD_IDLE, PD_BUSY} sccr_pd_state_t;

endpackage

// ### logic/sccr_regs.sv
// Configuration capability registers 58h to 70h of a four-port switch port
`timescale 1ns/1ps

module sccr_regs (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_downstream,
  input wire sccr_pkg::sccr_cfg_req_t i_cfg_req,
  output logic o_cfg_rvalid,
  output logic o_cfg_hit,
  output logic [31:0] o_cfg_rdata,
  output sccr_pkg::sccr_ee_req_t o_ee_req,
  input wire logic i_ee_done,
  input wire logic [31:0] i_ee_rdata,
  output logic [31:0] o_pd_rdata,
  input wire logic i_dflt_load,
  input wire logic [31:0] i_dflt_word,
  input wire logic [11:0] i_replay_builtin,
  input wire logic [13:0] i_ack_builtin,
  output logic [11:0] o_replay_timeout,
  output logic [13:0] o_ack_latency,
  output logic o_pm_cap_disable,
  output logic o_msi_cap_disable,
  input wire logic i_msi_enable,
  input wire logic [29:0] i_msi_addr,
  input wire logic i_irq_event,
  input wire logic i_msi_ready,
  output sccr_pkg::sccr_msi_wr_t o_msi_wr
);
  import sccr_pkg::*;

  // ****************************************
  // Byte-lane merge
  // ****************************************
  function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  logic [15:0] msg_payload_r;
  logic [5:0] pd_index_r;
  logic pd_flag_r;
  sccr_pd_state_t pd_state_r;
  logic [31:0] test_a_r;
  logic [31:0] test_b_r;
  logic [11:0] replay_user_r;
  logic replay_en_r;
  logic pm_dis_r;
  logic msi_dis_r;
  logic [13:0] ack_user_r;
  logic ack_en_r;

  logic wr_en;
  logic [31:0] wr_word;
  logic [31:0] pd_word;
  logic [31:0] timer_word;
  logic [31:0] rd_word;
  logic rd_hit;

  assign wr_en = i_cfg_req.valid && i_cfg_req.write;

  // ****************************************
  // Write decode
  // ****************************************
  logic wr_msg;
  logic wr_pd;
  logic wr_tsa;
  logic wr_tsb;
  logic wr_tmr;

  always_comb begin
    wr_msg = 1'b0;
    wr_pd = 1'b0;
    wr_tsa = 1'b0;
    wr_tsb = 1'b0;
    wr_tmr = 1'b0;
    if (wr_en) begin
      if (i_cfg_req.addr == OFF_MSG_PAYLOAD) begin
        // Payload exists only on a downstream port
        wr_msg = i_downstream;
      end else if (i_cfg_req.addr == OFF_PD_ACCESS) begin
        // Product-data access exists only on the upstream port
        wr_pd = !i_downstream;
      end else if (i_cfg_req.addr == OFF_TEST_A) begin
        wr_tsa = 1'b1;
      end else if (i_cfg_req.addr == OFF_TEST_B) begin
        wr_tsb = 1'b1;
      end else if (i_cfg_req.addr == OFF_TIMER_OVR) begin
        wr_tmr = 1'b1;
      end
    end
  end

  // ****************************************
  // Assembled register images
  // ****************************************
  always_comb begin
    pd_word = 32'h0000_0000;
    pd_word[7:0] = PD_CAP_ID;
    pd_word[15:8] = PD_NEXT_PTR;
    pd_word[PD_INDEX_MSB:PD_INDEX_LSB] = pd_index_r;
    pd_word[PD_FLAG_BIT] = pd_flag_r;
  end

  always_comb begin
    timer_word = 32'h0000_0000;
    timer_word[REPLAY_USER_MSB:0] = replay_user_r;
    timer_word[REPLAY_EN_BIT] = replay_en_r;
    timer_word[PM_DIS_BIT] = pm_dis_r;
    timer_word[MSI_DIS_BIT] = msi_dis_r;
    timer_word[ACK_USER_MSB:ACK_USER_LSB] = ack_user_r;
    timer_word[ACK_EN_BIT] = ack_en_r;
    timer_word[VGA_BIT] = VGA_DECODE_VAL;
  end

  // ****************************************
  // Read decode
  // ****************************************
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    if (i_cfg_req.addr == OFF_MSG_PAYLOAD) begin
      rd_word = i_downstream ? {16'h0000, msg_payload_r} : 32'h0000_0000;
    end else if (i_cfg_req.addr == OFF_PD_ACCESS) begin
      rd_word = i_downstream ? 32'h0000_0000 : pd_word;
    end else if (i_cfg_req.addr == OFF_VENDOR_CAP) begin
      rd_word = {VENDOR_CAP_LEN, VENDOR_NEXT_PTR, VENDOR_CAP_ID};
    end else if (i_cfg_req.addr == OFF_TEST_A) begin
      rd_word = test_a_r;
    end else if (i_cfg_req.addr == OFF_TEST_B) begin
      rd_word = test_b_r;
    end else if (i_cfg_req.addr == OFF_TIMER_OVR) begin
      rd_word = timer_word;
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_cfg_rvalid <= 1'b0;
      o_cfg_hit <= 1'b0;
    end else begin
      o_cfg_rvalid <= i_cfg_req.valid && !i_cfg_req.write;
      o_cfg_hit <= i_cfg_req.valid && rd_hit;
    end
  end

  // Read data holds until the next read
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_cfg_rdata <= 32'h0000_0000;
    end else if (i_cfg_req.valid && !i_cfg_req.write) begin
      o_cfg_rdata <= rd_word;
    end
  end

  // ****************************************
  // Message payload (downstream only)
  // ****************************************
  logic [31:0] pay_wr;
  assign pay_wr = be_merge({16'h0000, msg_payload_r}, i_cfg_req.wdata, i_cfg_req.be);

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      msg_payload_r <= MSG_PAYLOAD_RST;
    end else if (wr_msg) begin
      msg_payload_r <= pay_wr[15:0];
    end
  end

  // ****************************************
  // Product-data access over EEPROM
  // ****************************************
  assign wr_word = be_merge(pd_word, i_cfg_req.wdata, i_cfg_req.be);

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      pd_state_r <= PD_IDLE;
      pd_index_r <= PD_INDEX_RST;
      pd_flag_r <= PD_FLAG_RST;
      o_ee_req <= '0;
      o_pd_rdata <= 32'h0000_0000;
    end else begin
      case (pd_state_r)
        PD_IDLE: begin
          o_ee_req.valid <= 1'b0;
          if (wr_pd) begin
            if (i_cfg_req.be[2]) begin
              pd_index_r <= wr_word[PD_INDEX_MSB:PD_INDEX_LSB];
            end
            if (i_cfg_req.be[3]) begin
              pd_flag_r <= wr_word[PD_FLAG_BIT];
              o_ee_req.valid <= 1'b1;
              o_ee_req.write <= wr_word[PD_FLAG_BIT];
              o_ee_req.index <= wr_word[PD_INDEX_MSB:PD_INDEX_LSB];
              pd_state_r <= PD_BUSY;
            end
          end
        end
        PD_BUSY: begin
          // Product-data register writes are dropped until the cycle ends
          o_ee_req.valid <= 1'b0;
          if (i_ee_done) begin
            if (!o_ee_req.write) begin
              o_pd_rdata <= i_ee_rdata;
            end
            pd_flag_r <= ~o_ee_req.write;
            pd_state_r <= PD_IDLE;
          end
        end
        default: begin
          pd_state_r <= PD_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Test control words
  // ****************************************
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      test_a_r <= TEST_A_RST;
    end else if (wr_tsa) begin
      test_a_r <= be_merge(test_a_r, i_cfg_req.wdata, i_cfg_req.be);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      test_b_r <= TEST_B_RST;
    end else if (wr_tsb) begin
      test_b_r <= be_merge(test_b_r, i_cfg_req.wdata, i_cfg_req.be);
    end
  end

  // ****************************************
  // Timer overrides and capability disables
  // ****************************************
  logic [31:0] tmr_wr;
  assign tmr_wr = be_merge(timer_word, i_cfg_req.wdata, i_cfg_req.be);

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      replay_user_r <= REPLAY_USER_RST;
      replay_en_r <= 1'b0;
    end else if (i_dflt_load) begin
      // Autoload wins over a config write in the same cycle
      replay_user_r <= i_dflt_word[REPLAY_USER_MSB:0];
      replay_en_r <= i_dflt_word[REPLAY_EN_BIT];
    end else if (wr_tmr) begin
      replay_user_r <= tmr_wr[REPLAY_USER_MSB:0];
      replay_en_r <= tmr_wr[REPLAY_EN_BIT];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      ack_user_r <= ACK_USER_RST;
      ack_en_r <= 1'b0;
    end else if (i_dflt_load) begin
      ack_user_r <= i_dflt_word[ACK_USER_MSB:ACK_USER_LSB];
      ack_en_r <= i_dflt_word[ACK_EN_BIT];
    end else if (wr_tmr) begin
      ack_user_r <= tmr_wr[ACK_USER_MSB:ACK_USER_LSB];
      ack_en_r <= tmr_wr[ACK_EN_BIT];
    end
  end

  // Capability disables are read-only: only reset and autoload change them
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      pm_dis_r <= 1'b0;
      msi_dis_r <= 1'b0;
    end else if (i_dflt_load) begin
      pm_dis_r <= i_dflt_word[PM_DIS_BIT];
      msi_dis_r <= i_dflt_word[MSI_DIS_BIT];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_replay_timeout <= REPLAY_USER_RST;
      o_ack_latency <= ACK_USER_RST;
    end else begin
      o_replay_timeout <= replay_en_r ? replay_user_r : i_replay_builtin;
      o_ack_latency <= ack_en_r ? ack_user_r : i_ack_builtin;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_pm_cap_disable <= 1'b0;
      o_msi_cap_disable <= 1'b0;
    end else begin
      o_pm_cap_disable <= pm_dis_r;
      o_msi_cap_disable <= msi_dis_r;
    end
  end

  // ****************************************
  // Interrupt message write request
  // ****************************************
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_msi_wr <= '0;
    end else if (o_msi_wr.valid) begin
      if (i_msi_ready) begin
        o_msi_wr.valid <= 1'b0;
      end
    end else if (i_irq_event && i_msi_enable && i_downstream) begin
      o_msi_wr.valid <= 1'b1;
      o_msi_wr.addr <= i_msi_addr;
      o_msi_wr.data <= msg_payload_r;
    end
  end

endmodule // sccr_regs

// ### tb/sccr_ee_model.sv
// Behavioural EEPROM engine answering product-data cycles after a delay
`timescale 1ns/1ps
module sccr_ee_model
  import sccr_pkg::*;
#(
  parameter int DELAY = 6
) (
  input wire logic i_clk,
  input wire sccr_pkg::sccr_ee_req_t i_req,
  output logic o_done,
  output logic [31:0] o_rdata
);
  int cnt = 0;
  logic [31:0] word = '0;
  always_ff @(posedge i_clk) begin
    if (i_req.valid) begin
      cnt <= DELAY;
      word <= 32'hC0DE_0000 | 32'(i_req.index);
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
  // One done pulse per cycle; data line shows the inverse while idle
  assign o_done = (cnt == 1);
  assign o_rdata = o_done ? word : ~word;
endmodule // sccr_ee_model

// ### tb/sccr_regs_assertions.sv
// Concurrent checks on the capability register group ports
`timescale 1ns/1ps
module sccr_regs_assertions
  import sccr_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_downstream,
  input wire sccr_pkg::sccr_cfg_req_t i_cfg_req,
  input wire logic o_cfg_rvalid,
  input wire logic [31:0] o_cfg_rdata,
  input wire sccr_pkg::sccr_ee_req_t o_ee_req,
  input wire logic i_msi_enable,
  input wire logic i_irq_event,
  input wire logic i_msi_ready,
  input wire sccr_pkg::sccr_msi_wr_t o_msi_wr
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  logic rd;
  assign rd = i_cfg_req.valid && !i_cfg_req.write;
  chk_vendor_header: assert property (
    rd && i_cfg_req.addr == 8'h64 |=> o_cfg_rdata == 32'h0034_B009) else $error("vendor header");
  chk_pd_header: assert property (
    rd && i_cfg_req.addr == 8'h5C && !i_downstream |=> o_cfg_rdata[15:0] == 16'h6403)
    else $error("product-data header");
  chk_payload_upper: assert property (
    rd && i_cfg_req.addr == 8'h58 && i_downstream |=> o_cfg_rdata[31:16] == 16'h0000)
    else $error("payload upper half");
  chk_vga_bit: assert property (
    rd && i_cfg_req.addr == 8'h70 |=> o_cfg_rdata[31] && !o_cfg_rdata[15]) else $error("vga bit");
  chk_ee_start: assert property (
    o_ee_req.valid |-> $past(i_cfg_req.valid && i_cfg_req.write && i_cfg_req.addr == 8'h5C
    && i_cfg_req.be[3]) && o_ee_req.write == $past(i_cfg_req.wdata[31])) else $error("ee start");
  chk_ee_pulse: assert property (
    o_ee_req.valid |=> !o_ee_req.valid) else $error("ee start not a pulse");
  chk_msi_cause: assert property (
    $rose(o_msi_wr.valid) |-> $past(i_irq_event && i_msi_enable && i_downstream))
    else $error("message without cause");
  chk_msi_hold: assert property (
    o_msi_wr.valid && !i_msi_ready |=> o_msi_wr.valid && $stable(o_msi_wr))
    else $error("message dropped early");
endmodule // sccr_regs_assertions

bind sccr_regs sccr_regs_assertions u_chk (.i_clk, .i_rstn, .i_downstream, .i_cfg_req,
  .o_cfg_rvalid, .o_cfg_rdata, .o_ee_req, .i_msi_enable, .i_irq_event, .i_msi_ready, .o_msi_wr);

// ### tb/sccr_regs_tb.sv
// Self-checking bench for the capability register group
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin failures++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, e); end end
module sccr_regs_tb;
  import sccr_pkg::*;
  logic i_clk = 0;
  logic i_rstn = 0;
  logic dn = 0;
  logic load = 0;
  logic en = 0;
  logic irq = 0;
  logic rdy = 0;
  logic rvalid, hit, done, pmd, msd;
  logic [31:0] rdata, pd, ee_rdata, d;
  logic [31:0] dword = '0;
  logic [11:0] rto;
  logic [13:0] ack;
  sccr_cfg_req_t req = '0;
  sccr_ee_req_t ee;
  sccr_msi_wr_t msi;
  logic [7:0] ra[5] = '{8'h5C, 8'h64, 8'h68, 8'h6C, 8'h70};
  logic [31:0] re[5] = '{32'h0000_6403, 32'h0034_B009, 32'h0400_1060, 32'h0400_0800,
    32'h8000_0000};
  int failures = 0;
  int checked = 0;
  always #12.5 i_clk = ~i_clk;
  sccr_regs uut (.i_clk, .i_rstn, .i_downstream(dn), .i_cfg_req(req), .o_cfg_rvalid(rvalid),
    .o_cfg_hit(hit), .o_cfg_rdata(rdata), .o_ee_req(ee), .i_ee_done(done),
    .i_ee_rdata(ee_rdata), .o_pd_rdata(pd), .i_dflt_load(load), .i_dflt_word(dword),
    .i_replay_builtin(12'h123), .i_ack_builtin(14'h0456), .o_replay_timeout(rto),
    .o_ack_latency(ack), .o_pm_cap_disable(pmd), .o_msi_cap_disable(msd),
    .i_msi_enable(en), .i_msi_addr(30'h0123_4567), .i_irq_event(irq), .i_msi_ready(rdy),
    .o_msi_wr(msi));
  sccr_ee_model u_ee (.i_clk, .i_req(ee), .o_done(done), .o_rdata(ee_rdata));
  task tick;
    @(posedge i_clk);
    #2;
  endtask
  task cfg(input logic w, input logic [7:0] a, input logic [3:0] b, input logic [31:0] v);
    tick;
    req = '{1'b1, w, a, b, v};
    tick;
    req.valid = 1'b0;
  endtask
  task rd(input logic [7:0] a);
    cfg(1'b0, a, 4'hF, 32'h0000_0000);
    // Read valid stands only in the cycle after the request
    d = rvalid ? rdata : 'x;
  endtask
  task poll(input logic e);
    for (int n = 0; n < 20 && d[31] !== e; n++) rd(8'h5C);
  endtask
  task wrap_up;
    $display("failures %0d checked %0d", failures, checked);
    if (failures == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #50us;
    failures++;
    wrap_up;
  end
  initial begin
    repeat (16) tick;
    i_rstn = 1'b1;
    for (int i = 0; i < 5; i++) begin
      rd(ra[i]);
      `CHK(d, re[i])
      `CHK(hit, 1'b1)
    end
    `CHK(rto, 12'h123)
    cfg(1'b1, 8'h68, 4'h1, 32'hFFFF_FFAA);
    rd(8'h68);
    `CHK(d, 32'h0400_10AA)
    cfg(1'b1, 8'h6C, 4'hF, 32'hA5A5_5A5A);
    rd(8'h6C);
    `CHK(d, 32'hA5A5_5A5A)
    rd(8'h60);
    `CHK({hit, d}, 33'h0_0000_0000)
    cfg(1'b1, 8'h70, 4'hF, 32'h5555_FABC);
    tick;
    `CHK(rto, 12'hABC)
    `CHK(ack, 14'h1555)
    rd(8'h70);
    `CHK(d, 32'hD555_1ABC)
    cfg(1'b1, 8'h70, 4'h3, 32'h0000_0ABC);
    tick;
    `CHK(rto, 12'h123)
    `CHK(ack, 14'h1555)
    load = 1'b1;
    dword = 32'h4000_6000;
    tick;
    load = 1'b0;
    tick;
    `CHK({pmd, msd}, 2'b11)
    rd(8'h70);
    `CHK(d, 32'hC000_6000)
    cfg(1'b1, 8'h5C, 4'hC, 32'h7F17_0000);
    rd(8'h5C);
    `CHK(d, 32'h0014_6403)
    poll(1'b1);
    `CHK(d, 32'h8014_6403)
    `CHK(pd, 32'hC0DE_0005)
    cfg(1'b1, 8'h5C, 4'h8, 32'h8000_0000);
    rd(8'h5C);
    `CHK(d[31], 1'b1)
    poll(1'b0);
    `CHK(d, 32'h0014_6403)
    i_rstn = 1'b0;
    dn = 1'b1;
    repeat (16) tick;
    i_rstn = 1'b1;
    cfg(1'b1, 8'h58, 4'hF, 32'hFFFF_BEEF);
    rd(8'h58);
    `CHK(d, 32'h0000_BEEF)
    en = 1'b1;
    irq = 1'b1;
    tick;
    irq = 1'b0;
    for (int n = 0; n < 4 && msi.valid !== 1'b1; n++) tick;
    `CHK(msi, {1'b1, 30'h0123_4567, 16'hBEEF})
    repeat (3) tick;
    `CHK(msi.valid, 1'b1)
    rdy = 1'b1;
    tick;
    rdy = 1'b0;
    `CHK(msi.valid, 1'b0)
    wrap_up;
  end
endmodule // sccr_regs_tb
